// ===== scd_divider_regs.sv
// Divider settings for synthesizer channels C and D behind a byte port.
// Assumes a single-cycle write/read strobe master on i_sys_clk.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps

// Notes on behaviour
// [R1] Channel D integer offset is 7 bits at 0x15, reset 0x40, bit 7 unused.
// [R2] Channel D ratio bits 7:0 come from register 0x16, reset zero.
// [R3] Channel D ratio bits 15:8 come from register 0x17, reset zero.
// [R4] Channel C ratio bits 20:16 come from 0x14 bits 4:0, bit 4 resets one.
// [R5] Channel D ratio bits 20:16 come from 0x18 bits 4:0.
// [R6] Channel C ratio bits 7:0 and 15:8 come from its byte-0 and byte-1.
// [R7] Software writes zero to reserved bit 5 of channel C byte 2.
module scd_divider_regs
    import scd_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_rd_valid,
    output logic      [FRAC_W-1:0] o_chan_c_frac_ratio,
    output logic      [FRAC_W-1:0] o_chan_d_frac_ratio,
    output logic      [INT_W-1:0]  o_chan_d_integer_offset
);

    logic [REG_CNT-1:0]      wr_hit;
    logic [REG_CNT-1:0][7:0] reg_value;
    logic [STAT_W-1:0]       update_set;
    logic [STAT_W-1:0]       update_flags;
    logic                    status_rd;

    // Address decode and storage, one slot per config register (status flags live elsewhere)
    generate
        for (genvar g = 0; g < REG_CNT; g++) begin : g_slot
            assign wr_hit[g] = i_wr_en && (i_addr == REG_OFFSET[g]);

            scd_byte_reg #(
                .RESET_VALUE (REG_RESET[g]),
                .WRITE_MASK  (REG_MASK[g])
            ) u_reg (
                .i_sys_clk (i_sys_clk),
                .i_rst     (i_rst),
                .i_wr_en   (wr_hit[g]),
                .i_wr_data (i_wr_data),
                .o_value   (reg_value[g])
            );
        end
    endgenerate

    // Field assembly; reserved bit 5 is stored but never reaches a ratio
    assign o_chan_c_frac_ratio[FRAC_MID_LSB-1:FRAC_LOW_LSB] = reg_value[SLOT_C_LOW]; // R6
    assign o_chan_c_frac_ratio[FRAC_HIGH_LSB-1:FRAC_MID_LSB] = reg_value[SLOT_C_MID]; // R6
    assign o_chan_c_frac_ratio[FRAC_W-1:FRAC_HIGH_LSB] =
        reg_value[SLOT_C_HIGH][FRAC_HIGH_W-1:0]; // R4
    assign o_chan_d_integer_offset = reg_value[SLOT_D_INT][INT_W-1:0]; // R1
    assign o_chan_d_frac_ratio[FRAC_MID_LSB-1:FRAC_LOW_LSB] = reg_value[SLOT_D_LOW]; // R2
    assign o_chan_d_frac_ratio[FRAC_HIGH_LSB-1:FRAC_MID_LSB] = reg_value[SLOT_D_MID]; // R3
    assign o_chan_d_frac_ratio[FRAC_W-1:FRAC_HIGH_LSB] =
        reg_value[SLOT_D_HIGH][FRAC_HIGH_W-1:0]; // R5

    // Per-channel update flags let software confirm a reprogram landed
    assign update_set[STAT_C_BIT] = |wr_hit[SLOT_C_HIGH:SLOT_C_LOW];
    assign update_set[STAT_D_BIT] = |wr_hit[SLOT_D_HIGH:SLOT_D_INT];
    assign status_rd = i_rd_en && (i_addr == OFF_UPDATE_STATUS);

    scd_sticky_flags #(
        .N (STAT_W)
    ) u_flags (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_set     (update_set),
        .i_clear   (status_rd),
        .o_flags   (update_flags)
    );

    // Config bytes are write-only; only the status register reads back
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_data <= 8'h00;
        end else if (status_rd) begin
            o_rd_data <= {{(DATA_W-STAT_W){1'b0}}, update_flags};
        end else begin
            o_rd_data <= 8'h00;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
        end
    end

    // Assertions

    sequence s_wr_d_int;
        i_wr_en && (i_addr == OFF_CHAN_D_INT);
    endsequence

    sequence s_wr_d_low;
        i_wr_en && (i_addr == OFF_CHAN_D_FRAC_LOW);
    endsequence

    sequence s_wr_d_mid;
        i_wr_en && (i_addr == OFF_CHAN_D_FRAC_MID);
    endsequence

    sequence s_wr_d_high;
        i_wr_en && (i_addr == OFF_CHAN_D_FRAC_HIGH);
    endsequence

    sequence s_wr_c_high;
        i_wr_en && (i_addr == OFF_CHAN_C_FRAC_HIGH);
    endsequence

    sequence s_wr_c_low_mid;
        i_wr_en && ((i_addr == OFF_CHAN_C_FRAC_LOW) ||
                    (i_addr == OFF_CHAN_C_FRAC_MID));
    endsequence

    sequence s_status_read;
        i_rd_en && (i_addr == OFF_UPDATE_STATUS);
    endsequence

    property p_d_int_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_wr_d_int |=> (o_chan_d_integer_offset == $past(i_wr_data[INT_W-1:0]));
    endproperty
    a_d_int_write: assert property (p_d_int_write) // R1
        else $error("Channel D integer offset not loaded from write");

    property p_d_int_reset;
        @(posedge i_sys_clk)
        $past(i_rst) |-> (o_chan_d_integer_offset == RST_D_INT[INT_W-1:0]);
    endproperty
    a_d_int_reset: assert property (p_d_int_reset) // R1
        else $error("Channel D integer offset reset value wrong");

    property p_d_int_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !(i_wr_en && (i_addr == OFF_CHAN_D_INT)) |=> $stable(o_chan_d_integer_offset);
    endproperty
    a_d_int_hold: assert property (p_d_int_hold) // R1
        else $error("Channel D integer offset changed without a write");

    property p_d_low_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_wr_d_low |=> (o_chan_d_frac_ratio[7:0] == $past(i_wr_data))
                       ##1 (o_chan_d_frac_ratio[7:0] == $past(i_wr_data, 2)
                            || $past(i_wr_en));
    endproperty
    a_d_low_write: assert property (p_d_low_write) // R2
        else $error("Channel D ratio low byte not loaded from write");

    property p_d_low_reset;
        @(posedge i_sys_clk)
        $past(i_rst) |-> (o_chan_d_frac_ratio[15:0] == 16'h0000);
    endproperty
    a_d_low_reset: assert property (p_d_low_reset) // R2
        else $error("Channel D ratio low bytes not zero after reset");

    property p_d_mid_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_wr_d_mid |=> (o_chan_d_frac_ratio[15:8] == $past(i_wr_data))
                       && $stable(o_chan_d_frac_ratio[7:0]);
    endproperty
    a_d_mid_write: assert property (p_d_mid_write) // R3
        else $error("Channel D ratio mid byte not loaded from write");

    property p_c_high_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_wr_c_high |=> (o_chan_c_frac_ratio[20:16] == $past(i_wr_data[4:0]))
                        && $stable(o_chan_c_frac_ratio[15:0]);
    endproperty
    a_c_high_write: assert property (p_c_high_write) // R4
        else $error("Channel C ratio high bits not loaded from write");

    property p_c_high_reset;
        @(posedge i_sys_clk)
        $past(i_rst) |-> (o_chan_c_frac_ratio ==
            {RST_FRAC_HIGH[FRAC_HIGH_W-1:0], RST_FRAC_MID, RST_FRAC_LOW});
    endproperty
    a_c_high_reset: assert property (p_c_high_reset) // R4
        else $error("Channel C ratio reset value wrong");

    property p_d_high_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_wr_d_high |=> (o_chan_d_frac_ratio[20:16] == $past(i_wr_data[4:0]))
                        && $stable(o_chan_d_integer_offset);
    endproperty
    a_d_high_write: assert property (p_d_high_write) // R5
        else $error("Channel D ratio high bits not loaded from write");

    property p_c_low_mid_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_wr_c_low_mid |=>
            (($past(i_addr) == OFF_CHAN_C_FRAC_LOW) ?
                (o_chan_c_frac_ratio[7:0] == $past(i_wr_data)) :
                (o_chan_c_frac_ratio[15:8] == $past(i_wr_data)));
    endproperty
    a_c_low_mid_write: assert property (p_c_low_mid_write) // R6
        else $error("Channel C ratio low or mid byte not loaded");

    property p_status_after_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        (s_wr_c_high ##1 s_status_read) |=> o_rd_valid && o_rd_data[STAT_C_BIT];
    endproperty
    a_status_after_write: assert property (p_status_after_write)
        else $error("Channel C update flag not reported");

    property p_read_valid_one;
        @(posedge i_sys_clk) disable iff (i_rst)
        (!i_rd_en ##1 !i_rd_en) |-> !o_rd_valid && (o_rd_data == 8'h00);
    endproperty
    a_read_valid_one: assert property (p_read_valid_one)
        else $error("Read data present without a read");

    sequence s_wr_d_any;
        i_wr_en && (i_addr >= OFF_CHAN_D_INT) && (i_addr <= OFF_CHAN_D_FRAC_HIGH);
    endsequence

    property p_d_int_unused;
        @(posedge i_sys_clk) disable iff (i_rst)
        reg_value[SLOT_D_INT][DATA_W-1:INT_W] == '0;
    endproperty
    a_d_int_unused: assert property (p_d_int_unused) // R1
        else $error("Channel D integer offset unused bit stored");

    property p_high_unused;
        @(posedge i_sys_clk) disable iff (i_rst)
        (reg_value[SLOT_C_HIGH][DATA_W-1:RSVD_BIT+1] == '0) &&
        (reg_value[SLOT_D_HIGH][DATA_W-1:RSVD_BIT+1] == '0);
    endproperty
    a_high_unused: assert property (p_high_unused) // R4 R5
        else $error("Unused high ratio bits stored");

    property p_d_high_reset;
        @(posedge i_sys_clk)
        $past(i_rst) |-> (o_chan_d_frac_ratio[FRAC_W-1:FRAC_HIGH_LSB] ==
            RST_FRAC_HIGH[FRAC_HIGH_W-1:0]);
    endproperty
    a_d_high_reset: assert property (p_d_high_reset) // R5
        else $error("Channel D ratio high bits reset value wrong");

    property p_c_low_reset;
        @(posedge i_sys_clk)
        $past(i_rst) |-> (o_chan_c_frac_ratio[FRAC_HIGH_LSB-1:0] ==
            {RST_FRAC_MID, RST_FRAC_LOW});
    endproperty
    a_c_low_reset: assert property (p_c_low_reset) // R6
        else $error("Channel C ratio low bytes not zero after reset");

    property p_c_low_mid_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !(i_wr_en && ((i_addr == OFF_CHAN_C_FRAC_LOW) || (i_addr == OFF_CHAN_C_FRAC_MID)))
            |=> $stable(o_chan_c_frac_ratio[FRAC_HIGH_LSB-1:0]);
    endproperty
    a_c_low_mid_hold: assert property (p_c_low_mid_hold) // R6
        else $error("Channel C ratio low bytes changed without a write");

    property p_d_low_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !(i_wr_en && (i_addr == OFF_CHAN_D_FRAC_LOW))
            |=> $stable(o_chan_d_frac_ratio[FRAC_MID_LSB-1:FRAC_LOW_LSB]);
    endproperty
    a_d_low_hold: assert property (p_d_low_hold) // R2
        else $error("Channel D ratio low byte changed without a write");

    property p_d_mid_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !(i_wr_en && (i_addr == OFF_CHAN_D_FRAC_MID))
            |=> $stable(o_chan_d_frac_ratio[FRAC_HIGH_LSB-1:FRAC_MID_LSB]);
    endproperty
    a_d_mid_hold: assert property (p_d_mid_hold) // R3
        else $error("Channel D ratio mid byte changed without a write");

    property p_c_high_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !(i_wr_en && (i_addr == OFF_CHAN_C_FRAC_HIGH))
            |=> $stable(o_chan_c_frac_ratio[FRAC_W-1:FRAC_HIGH_LSB]);
    endproperty
    a_c_high_hold: assert property (p_c_high_hold) // R4
        else $error("Channel C ratio high bits changed without a write");

    property p_d_high_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !(i_wr_en && (i_addr == OFF_CHAN_D_FRAC_HIGH))
            |=> $stable(o_chan_d_frac_ratio[FRAC_W-1:FRAC_HIGH_LSB]);
    endproperty
    a_d_high_hold: assert property (p_d_high_hold) // R5
        else $error("Channel D ratio high bits changed without a write");

    property p_rd_valid_follow;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_rd_en |=> o_rd_valid;
    endproperty
    a_rd_valid_follow: assert property (p_rd_valid_follow)
        else $error("Read valid missing after a read strobe");

    property p_rd_write_only;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd_en && (i_addr != OFF_UPDATE_STATUS)) |=> (o_rd_data == 8'h00);
    endproperty
    a_rd_write_only: assert property (p_rd_write_only)
        else $error("Write-only register returned data");

    property p_status_d_after_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        (s_wr_d_any ##1 s_status_read) |=> o_rd_valid && o_rd_data[STAT_D_BIT];
    endproperty
    a_status_d_after_write: assert property (p_status_d_after_write)
        else $error("Channel D update flag not reported");

    // Two idle cycles between reads rule out a fresh set
    property p_status_clear;
        @(posedge i_sys_clk) disable iff (i_rst)
        (s_status_read ##1 (!i_wr_en) [*2] ##1 s_status_read) |=> (o_rd_data == 8'h00);
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("Update flags not cleared by a status read");

endmodule : scd_divider_regs

// ===== scd_pkg.sv
// Constants for the two-channel synthesizer divider register bank.
// Assumes byte-wide register access at the printed byte offsets.
package scd_pkg;

    localparam int REG_CNT = 7;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;

    // Register offsets
    localparam logic [7:0] OFF_CHAN_C_FRAC_LOW  = 8'h12;
    localparam logic [7:0] OFF_CHAN_C_FRAC_MID  = 8'h13;
    localparam logic [7:0] OFF_CHAN_C_FRAC_HIGH = 8'h14;
    localparam logic [7:0] OFF_CHAN_D_INT       = 8'h15;
    localparam logic [7:0] OFF_CHAN_D_FRAC_LOW  = 8'h16;
    localparam logic [7:0] OFF_CHAN_D_FRAC_MID  = 8'h17;
    localparam logic [7:0] OFF_CHAN_D_FRAC_HIGH = 8'h18;
    localparam logic [7:0] OFF_UPDATE_STATUS    = 8'h1F;

    // Reset values
    localparam logic [7:0] RST_FRAC_LOW  = 8'h00;
    localparam logic [7:0] RST_FRAC_MID  = 8'h00;
    localparam logic [7:0] RST_FRAC_HIGH = 8'h10;
    localparam logic [7:0] RST_D_INT     = 8'h40;

    // Implemented bits; unused bits hold zero
    localparam logic [7:0] MASK_FULL      = 8'hFF;
    localparam logic [7:0] MASK_FRAC_HIGH = 8'h3F;
    localparam logic [7:0] MASK_D_INT     = 8'h7F;

    // Field layout
    localparam int FRAC_W        = 21;
    localparam int INT_W         = 7;
    localparam int FRAC_HIGH_W   = 5;
    localparam int FRAC_LOW_LSB  = 0;
    localparam int FRAC_MID_LSB  = 8;
    localparam int FRAC_HIGH_LSB = 16;
    localparam int RSVD_BIT      = 5;

    // Update status bits
    localparam int STAT_W      = 2;
    localparam int STAT_C_BIT  = 0;
    localparam int STAT_D_BIT  = 1;

    // Register slots, index order C low..D high
    localparam logic [REG_CNT-1:0][7:0] REG_OFFSET = {
        OFF_CHAN_D_FRAC_HIGH, OFF_CHAN_D_FRAC_MID, OFF_CHAN_D_FRAC_LOW,
        OFF_CHAN_D_INT, OFF_CHAN_C_FRAC_HIGH, OFF_CHAN_C_FRAC_MID,
        OFF_CHAN_C_FRAC_LOW};
    localparam logic [REG_CNT-1:0][7:0] REG_RESET = {
        RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW, RST_D_INT,
        RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW};
    localparam logic [REG_CNT-1:0][7:0] REG_MASK = {
        MASK_FRAC_HIGH, MASK_FULL, MASK_FULL, MASK_D_INT,
        MASK_FRAC_HIGH, MASK_FULL, MASK_FULL};

    localparam int SLOT_C_LOW  = 0;
    localparam int SLOT_C_MID  = 1;
    localparam int SLOT_C_HIGH = 2;
    localparam int SLOT_D_INT  = 3;
    localparam int SLOT_D_LOW  = 4;
    localparam int SLOT_D_MID  = 5;
    localparam int SLOT_D_HIGH = 6;

endpackage : scd_pkg

// ===== scd_byte_reg.sv
// One write-only configuration byte with reset value and bit mask.
// Assumes a one-cycle write enable from the same clock domain.
`timescale 1ns/100ps
module scd_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    output logic      [7:0] o_value
);

    // Masked bits never leave zero, so unused bits cannot leak into fields
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_value <= RESET_VALUE;
        end else if (i_wr_en) begin
            o_value <= i_wr_data & WRITE_MASK;
        end
    end

endmodule : scd_byte_reg

// ===== scd_sticky_flags.sv
// Sticky event flags cleared as a group.
// Assumes set and clear pulses from the same clock domain.
`timescale 1ns/100ps
module scd_sticky_flags #(
    parameter int N = 2
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic [N-1:0] i_set,
    input  wire logic         i_clear,
    output logic      [N-1:0] o_flags
);

    logic [N-1:0] next_flags;

    // Set wins over a clear in the same cycle
    always_comb begin
        next_flags = (i_clear ? '0 : o_flags) | i_set;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_flags <= '0;
        end else begin
            o_flags <= next_flags;
        end
    end

endmodule : scd_sticky_flags

// ===== tb.sv
// Self-checking bench for the channel C/D divider register bank.
// Assumes the bank's one-cycle strobe port and a single 250 MHz clock.
`timescale 1ns/100ps
module tb;
    import scd_pkg::*;
    logic              i_sys_clk;
    logic              i_rst;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wr_data;
    logic              i_wr_en;
    logic              i_rd_en;
    logic [DATA_W-1:0] o_rd_data;
    logic              o_rd_valid;
    logic [FRAC_W-1:0] o_chan_c_frac_ratio;
    logic [FRAC_W-1:0] o_chan_d_frac_ratio;
    logic [INT_W-1:0]  o_chan_d_integer_offset;
    int                n_errors;
    int                cmp_count;
    int                m_reg [7];
    int                m_flags;
    logic [31:0]       lfsr;

    scd_divider_regs scd_divider_regs_inst (
        .i_sys_clk               (i_sys_clk),
        .i_rst                   (i_rst),
        .i_addr                  (i_addr),
        .i_wr_data               (i_wr_data),
        .i_wr_en                 (i_wr_en),
        .i_rd_en                 (i_rd_en),
        .o_rd_data               (o_rd_data),
        .o_rd_valid              (o_rd_valid),
        .o_chan_c_frac_ratio     (o_chan_c_frac_ratio),
        .o_chan_d_frac_ratio     (o_chan_d_frac_ratio),
        .o_chan_d_integer_offset (o_chan_d_integer_offset)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr_next

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic model_reset();
        m_reg = '{int'(RST_FRAC_LOW), int'(RST_FRAC_MID), int'(RST_FRAC_HIGH),
                  int'(RST_D_INT), int'(RST_FRAC_LOW), int'(RST_FRAC_MID),
                  int'(RST_FRAC_HIGH)};
        m_flags = 0;
    endtask : model_reset

    task automatic chk_outs();
        chk(32'(o_chan_c_frac_ratio), 32'(((m_reg[2] & 32'h1F) << 16) | (m_reg[1] << 8) | m_reg[0]));
        chk(32'(o_chan_d_integer_offset), 32'(m_reg[3] & 32'h7F));
        chk(32'(o_chan_d_frac_ratio[7:0]), 32'(m_reg[4]));
        chk(32'(o_chan_d_frac_ratio[15:8]), 32'(m_reg[5]));
        chk(32'(o_chan_d_frac_ratio[20:16]), 32'(m_reg[6] & 32'h1F));
    endtask : chk_outs

    // Strobe is left high so consecutive calls give back-to-back writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_rd_en   <= 1'b0;
        i_wr_en   <= 1'b1;
        i_addr    <= a;
        i_wr_data <= d;
        if (a >= 8'h12 && a <= 8'h18) m_reg[a - 8'h12] = d;
        if (a >= 8'h12 && a <= 8'h14) m_flags |= 1;
        if (a >= 8'h15 && a <= 8'h18) m_flags |= 2;
    endtask : wr

    task automatic idle();
        @(posedge i_sys_clk);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b0;
        #1;
        chk_outs();
    endtask : idle

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        @(posedge i_sys_clk);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b1;
        i_addr  <= a;
        @(posedge i_sys_clk);
        i_rd_en <= 1'b0;
        #1;
        e = (a == 8'h1F) ? 8'(m_flags) : 8'h00;
        if (a == 8'h1F) m_flags = 0;
        chk(32'(o_rd_valid), 32'h1);
        chk(32'(o_rd_data), 32'(e));
        chk_outs();
        @(posedge i_sys_clk);
        #1;
        chk(32'(o_rd_valid), 32'h0);
        chk(32'(o_rd_data), 32'h0);
    endtask : rd

    task automatic pulse_reset();
        @(posedge i_sys_clk);
        i_rst   <= 1'b1;
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        model_reset();
        #1;
        chk_outs();
    endtask : pulse_reset

    initial begin
        #400000;
        n_errors++;
        $display("ERROR at %0t: run did not finish", $time);
        end_sim();
    end

    initial begin
        logic [7:0] a;
        logic [7:0] d;
        i_rst = 1'b1;
        i_addr = 8'h00;
        i_wr_data = 8'h00;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        lfsr = 32'hA45D59D5;
        model_reset();
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        chk_outs();
        rd(8'h1F);
        $display("Test reset_defaults done");
        // Each byte alone, then all ones (0xDF for 0x14) to probe unused bits
        for (int k = 0; k < 7; k++) begin
            lfsr = lfsr_next(lfsr);
            d = (k == 2) ? (lfsr[7:0] & 8'hDF) : lfsr[7:0];
            wr(8'h12 + 8'(k), d);
            idle();
            wr(8'h12 + 8'(k), (k == 2) ? 8'hDF : 8'hFF);
            idle();
        end
        $display("Test per_byte done");
        for (int k = 8'h10; k <= 8'h1F; k++) rd(8'(k));
        $display("Test write_only_reads done");
        wr(8'h16, 8'hAB);
        wr(8'h17, 8'h00);
        wr(8'h18, 8'h01);
        wr(8'h15, 8'h00);
        wr(8'h11, 8'h5A);
        wr(8'h19, 8'hA5);
        wr(8'h1F, 8'hFF);
        rd(8'h1F);
        rd(8'h1F);
        wr(8'h13, 8'h3C);
        wr(8'h14, 8'h0C);
        rd(8'h1F);
        wr(8'h18, 8'h0A);
        rd(8'h1F);
        $display("Test back_to_back done");
        for (int n = 0; n < 300; n++) begin
            lfsr = lfsr_next(lfsr);
            a = 8'h10 + 8'(lfsr[3:0]);
            d = lfsr[15:8];
            if (a == 8'h14) d[5] = 1'b0;
            if (lfsr[20]) begin
                rd(a);
            end else begin
                wr(a, d);
                if (lfsr[21]) idle();
            end
        end
        idle();
        $display("Test random_traffic done");
        wr(8'h15, 8'h01);
        pulse_reset();
        rd(8'h1F);
        $display("Test mid_run_reset done");
        end_sim();
    end
endmodule : tb
